// ### hw/coarse_loss_latch.sv
`timescale 1ns/1ps
module coarse_loss_latch (
   input  wire logic clk,          // System clock
   input  wire logic sys_rst,      // Async reset, active high
   input  wire logic enable,       // Coarse detector enable
   input  wire logic phase_lost,   // Coarse detector raw indication
   output logic      latched       // Held phase-lost indication
);

   logic latched_q;
   logic latched_d;

   // Holds until the enable is dropped; a new enable starts from the
   // current loop state because the hold is empty by then.
   always_comb begin
      latched_d = enable & (latched_q | phase_lost); // R2 R5 R6
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         latched_q <= lock_status_pkg::COARSE_LATCH_RESET;
      end else begin
         latched_q <= latched_d;
      end
   end

   assign latched = latched_q;

   coarse_set_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
      enable && phase_lost |=> latched_q)
      else $error("coarse loss not latched");

   coarse_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
      latched_q && enable |=> latched_q)
      else $error("coarse latch dropped while enabled");

   coarse_release_a: assert property (@(posedge clk) disable iff (sys_rst) // R6
      !enable |=> !latched_q)
      else $error("coarse latch not released by disable");

endmodule

// ### hw/secondary_lock_status.sv
`timescale 1ns/1ps
// What this block does
// R1: Lock merges four enabled phase-loss sources.
// R2: Coarse phase loss is latched while enabled.
// R3: Software toggles coarse enable for fresh reading.
// R4: Locked reading stays live without enable change.
// R5: Later coarse events latch lock low.
// R6: Only disabling coarse detector releases latch.
module secondary_lock_status (
   input  wire logic       clk,                         // System clock, 250 MHz
   input  wire logic       sys_rst,                     // Async reset, active high
   input  wire logic       fine_loss_en,                // Fine detector enable
   input  wire logic       coarse_loss_en,              // Coarse detector enable
   input  wire logic       no_activity_en,              // No-activity detector enable
   input  wire logic       freq_limit_en,               // Frequency-limit detector enable
   input  wire logic       fine_phase_lost,             // Fine detector indication
   input  wire logic       coarse_phase_lost,           // Coarse detector indication
   input  wire logic       input_no_activity,           // Reference shows no activity
   input  wire logic       freq_limit_hit,              // Loop at min or max frequency
   input  wire logic       main_loop_freq_warning,      // Main loop soft alarm
   input  wire logic       secondary_loop_freq_warning, // Secondary loop soft alarm
   input  wire logic [2:0] main_loop_state,             // Main loop state code
   output logic [7:0]      loop_operating_status,       // Status register read value
   output logic            secondary_loop_locked,       // Lock bit, registered
   output logic            coarse_loss_held             // Coarse latch state
);

   logic       coarse_latched;
   logic       fine_loss;
   logic       activity_loss;
   logic       limit_loss;
   logic       live_loss;
   logic [3:0] hold_age_q;
   logic [3:0] hold_age_d;
   logic       any_loss;
   logic [7:0] status_q;
   logic [7:0] status_d;

   // One gate per source; each enable is the same one the main loop uses
   function automatic logic gated(input logic en, input logic src);
      gated = en & src;
   endfunction

   // Software gets a fresh reading only by dropping the coarse enable,
   // reading, then raising it again; slips while it is low go unseen.
   coarse_loss_latch i_coarse_loss_latch (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .enable     (coarse_loss_en),
      .phase_lost (coarse_phase_lost),
      .latched    (coarse_latched)
   );

   // Non-coarse sources are live: once locked the bit follows them
   // directly, so no enable toggling is needed to keep it current.
   always_comb begin
      fine_loss     = gated(fine_loss_en, fine_phase_lost);      // R1
      activity_loss = gated(no_activity_en, input_no_activity);  // R1
      limit_loss    = gated(freq_limit_en, freq_limit_hit);      // R1
      live_loss     = fine_loss | activity_loss | limit_loss;    // R1 R4
      any_loss      = live_loss | coarse_latched;                // R1 R2 R5
   end

   // Status register assembly; unused bits 7 and 3 read as zero
   always_comb begin
      status_d = 8'h00;
      status_d[lock_status_pkg::LOCK_BIT]      = ~any_loss;  // R2 R4 R5
      status_d[lock_status_pkg::MAIN_WARN_BIT] = main_loop_freq_warning;
      status_d[lock_status_pkg::SEC_WARN_BIT]  = secondary_loop_freq_warning;
      status_d[lock_status_pkg::STATE_LSB +: lock_status_pkg::STATE_W] = main_loop_state;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_q <= lock_status_pkg::STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   assign loop_operating_status = status_q;
   assign secondary_loop_locked = status_q[lock_status_pkg::LOCK_BIT];
   assign coarse_loss_held      = coarse_latched;

   // Age of a held coarse fault, saturating at all ones. It lets one check
   // span a long hold rather than a fixed window; it empties with the latch.
   always_comb begin
      hold_age_d = 4'h0;
      if (coarse_latched && coarse_loss_en) begin
         hold_age_d = (&hold_age_q) ? hold_age_q : 4'(hold_age_q + 4'h1);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_age_q <= {4{lock_status_pkg::COARSE_LATCH_RESET}};
      end else begin
         hold_age_q <= hold_age_d;
      end
   end

   // Any enabled live source clears the lock bit on the next edge
   live_loss_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
      live_loss |=> !secondary_loop_locked)
      else $error("enabled loss source did not clear lock");

   // A disabled source must not affect the lock bit
   gate_fine_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
      !fine_loss_en && !no_activity_en && !freq_limit_en && !coarse_latched
      |=> secondary_loop_locked)
      else $error("disabled sources still clear lock");

   // Coarse event while enabled keeps lock low two edges later
   coarse_lock_low_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
      coarse_loss_en && coarse_phase_lost |-> ##2 !secondary_loop_locked)
      else $error("coarse event did not clear lock");

   // Held low as long as the coarse detector stays enabled
   fault_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
      coarse_latched && coarse_loss_en |-> ##1 !secondary_loop_locked [*2])
      else $error("lock bit rose while coarse fault held");

   // Live indication: with no loss the bit reads locked next cycle
   live_locked_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
      !any_loss |=> secondary_loop_locked)
      else $error("lock bit not live when loss absent");

   // Disable then re-enable gives a fresh reading from the loop
   release_a: assert property (@(posedge clk) disable iff (sys_rst) // R6
      !coarse_loss_en ##1 (coarse_loss_en && !coarse_phase_lost && !live_loss)
      |=> secondary_loop_locked)
      else $error("lock not fresh after coarse re-enable");

   state_mirror_a: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=> loop_operating_status[2:0] == $past(main_loop_state)
               && loop_operating_status[7] == 1'b0
               && loop_operating_status[3] == 1'b0)
      else $error("status fields not mirrored");

   // Warning bits pass through one register stage
   warn_mirror_a: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=> loop_operating_status[5] == $past(main_loop_freq_warning)
               && loop_operating_status[4] == $past(secondary_loop_freq_warning))
      else $error("warning bits not mirrored");

   // Status and latch sit at their reset values after a reset edge
   reset_state_a: assert property (@(posedge clk)
      sys_rst |=> loop_operating_status == lock_status_pkg::STATUS_RESET
                  && !coarse_loss_held)
      else $error("status not at reset value after reset");

   // Each enabled live source on its own clears the lock bit
   fine_src_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
      fine_loss_en && fine_phase_lost |=> !secondary_loop_locked)
      else $error("fine loss did not clear lock");

   activity_src_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
      no_activity_en && input_no_activity |=> !secondary_loop_locked)
      else $error("no-activity loss did not clear lock");

   limit_src_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
      freq_limit_en && freq_limit_hit |=> !secondary_loop_locked)
      else $error("frequency-limit loss did not clear lock");

   // A disabled source is ignored whatever its raw indication says
   fine_off_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
      !fine_loss_en && !activity_loss && !limit_loss && !coarse_latched
      |=> secondary_loop_locked)
      else $error("disabled fine source cleared lock");

   activity_off_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
      !no_activity_en && !fine_loss && !limit_loss && !coarse_latched
      |=> secondary_loop_locked)
      else $error("disabled no-activity source cleared lock");

   limit_off_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
      !freq_limit_en && !fine_loss && !activity_loss && !coarse_latched
      |=> secondary_loop_locked)
      else $error("disabled frequency-limit source cleared lock");

   // A held coarse fault shows as not locked one edge later
   held_low_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
      coarse_loss_held |=> !secondary_loop_locked)
      else $error("held coarse fault did not clear lock");

   // A slip while locked and enabled is caught and then flagged
   slip_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
      secondary_loop_locked && coarse_loss_en && coarse_phase_lost
      |=> coarse_loss_held ##1 !secondary_loop_locked)
      else $error("slip while locked not flagged");

   // Long hold: lock stays low for as long as the fault age counts
   fault_age_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
      hold_age_q != 4'h0 |-> !secondary_loop_locked)
      else $error("lock bit rose during long coarse hold");

   // With the coarse detector off, slips are ignored and the bit is live
   coarse_off_a: assert property (@(posedge clk) disable iff (sys_rst) // R6
      !coarse_loss_en ##1 !coarse_loss_en
      |=> secondary_loop_locked == !$past(live_loss))
      else $error("lock bit not live while coarse detector off");

   // Every change of the lock bit is explained by the cycle before it
   lock_fall_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
      $fell(secondary_loop_locked) |-> $past(any_loss))
      else $error("lock bit fell with no loss present");

   lock_rise_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
      $rose(secondary_loop_locked) |-> !$past(any_loss))
      else $error("lock bit rose while loss present");

   coarse_fault_c: cover property (@(posedge clk) disable iff (sys_rst)
      coarse_loss_en && coarse_phase_lost ##1 coarse_latched ##1 !secondary_loop_locked);

   toggle_read_c: cover property (@(posedge clk) disable iff (sys_rst)
      coarse_latched ##1 !coarse_loss_en ##1 coarse_loss_en ##1 secondary_loop_locked);

   fine_loss_c: cover property (@(posedge clk) disable iff (sys_rst)
      gated(fine_loss_en, fine_phase_lost) ##1 !secondary_loop_locked);

   relock_c: cover property (@(posedge clk) disable iff (sys_rst)
      !secondary_loop_locked ##1 secondary_loop_locked);

   long_hold_c: cover property (@(posedge clk) disable iff (sys_rst)
      (&hold_age_q) ##1 !secondary_loop_locked);

endmodule

// ### inc/lock_status_pkg.sv
package lock_status_pkg;

   // Status register map
   localparam logic [7:0] STATUS_OFFSET        = 8'h09;
   localparam logic [7:0] STATUS_RESET         = 8'h41;
   localparam int         LOCK_BIT             = 6;
   localparam int         MAIN_WARN_BIT        = 5;
   localparam int         SEC_WARN_BIT         = 4;
   localparam int         STATE_LSB            = 0;
   localparam int         STATE_W              = 3;

   // Where each source enable lives in the configuration bank
   localparam logic [7:0] FINE_EN_OFFSET       = 8'h73;
   localparam int         FINE_EN_BIT          = 7;
   localparam logic [7:0] NO_ACTIVITY_EN_OFFSET = 8'h73;
   localparam int         NO_ACTIVITY_EN_BIT   = 6;
   localparam logic [7:0] COARSE_EN_OFFSET     = 8'h74;
   localparam int         COARSE_EN_BIT        = 7;
   localparam logic [7:0] FREQ_LIMIT_EN_OFFSET = 8'h4d;
   localparam int         FREQ_LIMIT_EN_BIT    = 7;

   // Reset values of the fields
   localparam logic       LOCKED_RESET         = 1'h1;
   localparam logic [2:0] MAIN_STATE_RESET     = 3'h1;
   localparam logic       COARSE_LATCH_RESET   = 1'h0;

endpackage

// ### verification/tb_secondary_lock_status.sv
`timescale 1ns/1ps
module tb_secondary_lock_status;
   logic       clk;
   logic       sys_rst;
   logic [3:0] en;       // 0 fine, 1 coarse, 2 no activity, 3 freq limit
   logic [3:0] lost;
   logic [1:0] warn;
   logic [2:0] state;
   logic [7:0] status;
   logic       locked;
   logic       held;
   int         err_total;
   int         tests_run;
   int         cyc;

   secondary_lock_status i_secondary_lock_status (
      .clk                         (clk),
      .sys_rst                     (sys_rst),
      .fine_loss_en                (en[0]),
      .coarse_loss_en              (en[1]),
      .no_activity_en              (en[2]),
      .freq_limit_en               (en[3]),
      .fine_phase_lost             (lost[0]),
      .coarse_phase_lost           (lost[1]),
      .input_no_activity           (lost[2]),
      .freq_limit_hit              (lost[3]),
      .main_loop_freq_warning      (warn[1]),
      .secondary_loop_freq_warning (warn[0]),
      .main_loop_state             (state),
      .loop_operating_status       (status),
      .secondary_loop_locked       (locked),
      .coarse_loss_held            (held)
   );

   always #2 clk = ~clk;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic conclude;
      $display("Comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Whole run needs well under a hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         conclude();
      end
   end

   initial begin
      clk = 0; sys_rst = 1; en = 4'h0; lost = 4'h0; warn = 2'h0; state = 3'h0;
      err_total = 0; tests_run = 0; cyc = 0;
      step(4);
      chk(status, 8'h41);
      chk({7'h0, held}, 8'h00);
      $display("test reset done");
      sys_rst = 0;
      for (int s = 0; s < 8; s++) begin
         state = s[2:0];
         warn = s[1:0];
         step(1);
         chk(status, {1'b0, 1'b1, s[1:0], 1'b0, s[2:0]});
      end
      $display("test fields done");
      foreach (en[i]) if (i != 1) begin
         lost[i] = 1; step(1);
         chk({7'h0, locked}, 8'h01);
         en[i] = 1; step(1);
         chk({7'h0, locked}, 8'h00);
         chk(status[7:0], {2'b00, warn, 1'b0, state});
         lost[i] = 0; step(1);
         chk({7'h0, locked}, 8'h01);
         en[i] = 0;
      end
      $display("test live sources done");
      lost[1] = 1; step(2);
      chk({7'h0, locked}, 8'h01);
      en[1] = 1; step(1);
      chk({7'h0, held}, 8'h01);
      lost[1] = 0; step(1);
      chk({7'h0, locked}, 8'h00);
      step(5);
      chk({6'h0, held, locked}, 8'h02);
      $display("test coarse latch done");
      en[1] = 0; step(2);
      chk({6'h0, held, locked}, 8'h01);
      en[1] = 1; step(2);
      chk({6'h0, held, locked}, 8'h01);
      en[0] = 1; lost[0] = 1; step(1);
      chk({7'h0, locked}, 8'h00);
      lost[0] = 0; step(1);
      chk({7'h0, locked}, 8'h01);
      $display("test re-read done");
      lost[1] = 1; step(1);
      lost[1] = 0; step(1);
      chk({6'h0, held, locked}, 8'h02);
      step(16);
      chk({6'h0, held, locked}, 8'h02);
      sys_rst = 1; step(1);
      chk(status, 8'h41);
      chk({6'h0, held, locked}, 8'h01);
      $display("test later slip done");
      conclude();
   end
endmodule
